// [hdl/dgr_global_regs.sv]
`timescale 1ns/100ps
module dgr_global_regs #(
  parameter logic [15:0] CONTROLLER_ID      = 16'h5a3c, // arbitrary value
  parameter logic [15:0] CHANNEL_ID         = 16'h5a3c, // arbitrary value
  parameter int          SOFT_RESET_CYCLES  = dgr_pkg::SOFT_RESET_PULSE_CYCLES
) (
  input  wire logic                       clock,           // 25 MHz system clock
  input  wire logic                       sys_rst,         // synchronous reset, high
  input  wire logic [dgr_pkg::ADDR_W-1:0] s_axi_awaddr,    // write address
  input  wire logic                       s_axi_awvalid,   // write address valid
  output logic                            s_axi_awready,   // write address ready
  input  wire logic [dgr_pkg::DATA_W-1:0] s_axi_wdata,     // write data
  input  wire logic [3:0]                 s_axi_wstrb,     // write byte strobes
  input  wire logic                       s_axi_wvalid,    // write data valid
  output logic                            s_axi_wready,    // write data ready
  output logic [1:0]                      s_axi_bresp,     // write response
  output logic                            s_axi_bvalid,    // write response valid
  input  wire logic                       s_axi_bready,    // write response ready
  input  wire logic [dgr_pkg::ADDR_W-1:0] s_axi_araddr,    // read address
  input  wire logic                       s_axi_arvalid,   // read address valid
  output logic                            s_axi_arready,   // read address ready
  output logic [dgr_pkg::DATA_W-1:0]      s_axi_rdata,     // read data
  output logic [1:0]                      s_axi_rresp,     // read response
  output logic                            s_axi_rvalid,    // read data valid
  input  wire logic                       s_axi_rready,    // read data ready
  output logic                            dma_soft_reset   // reset pulse to the rest of the DMA
);

  logic [dgr_pkg::ADDR_W-1:0] wr_addr;
  logic [dgr_pkg::DATA_W-1:0] wr_data;
  logic [3:0]                 wr_strb;
  logic                       aw_held;
  logic                       w_held;
  logic [dgr_pkg::ADDR_W-1:0] rd_addr;
  logic                       rd_wait;
  logic                       soft_trigger;
  dgr_pkg::dgr_rd_t           rd_word;

  wire logic aw_take   = s_axi_awvalid && s_axi_awready;
  wire logic w_take    = s_axi_wvalid && s_axi_wready;
  wire logic b_done    = s_axi_bvalid && s_axi_bready;
  wire logic ar_take   = s_axi_arvalid && s_axi_arready;
  wire logic r_done    = s_axi_rvalid && s_axi_rready;
  wire logic wr_commit = aw_held && w_held && !s_axi_bvalid;

  wire logic wr_hit    = dgr_pkg::reg_mapped(wr_addr);
  // only the reset trigger is writable; every other mapped register drops the data
  wire logic wr_reset  = wr_commit && wr_hit &&
                         (dgr_pkg::reg_index(wr_addr) == dgr_pkg::IDX_SOFT_RESET_CONTROL) &&
                         wr_strb[0] && wr_data[dgr_pkg::SOFT_RESET_TRIGGER_BIT];

  // write address and data are taken in either order and held until the response
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_addr       <= '0;
      aw_held       <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (aw_take) begin
      wr_addr       <= s_axi_awaddr;
      aw_held       <= 1'b1;
      s_axi_awready <= 1'b0;
    end else if (b_done) begin
      aw_held       <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_data      <= '0;
      wr_strb      <= '0;
      w_held       <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (w_take) begin
      wr_data      <= s_axi_wdata;
      wr_strb      <= s_axi_wstrb;
      w_held       <= 1'b1;
      s_axi_wready <= 1'b0;
    end else if (b_done) begin
      w_held       <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dgr_pkg::RESP_OKAY;
      soft_trigger <= 1'b0;
    end else begin
      soft_trigger <= wr_reset;
      if (wr_commit) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? dgr_pkg::RESP_OKAY : dgr_pkg::RESP_SLVERR;
      end else if (b_done) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read: address held in rd_addr, the mux registers the word one cycle later
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_addr       <= '0;
      rd_wait       <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end else begin
      rd_wait <= ar_take;
      if (ar_take) begin
        rd_addr       <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end
      if (rd_wait) begin
        s_axi_rvalid <= 1'b1;
      end else if (r_done) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  assign s_axi_rdata = rd_word.data;
  assign s_axi_rresp = rd_word.resp;

  dgr_read_mux #(
    .CONTROLLER_ID (CONTROLLER_ID),
    .CHANNEL_ID    (CHANNEL_ID)
  ) u_read_mux (
    .clock   (clock),
    .sys_rst (sys_rst),
    .rd_addr (rd_addr),
    .rd_word (rd_word)
  );

  // the bus slave stays out of the pulse it raises, so the write response survives it
  dgr_soft_reset_gen #(
    .PULSE_CYCLES (SOFT_RESET_CYCLES)
  ) u_soft_reset (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .trigger   (soft_trigger),
    .dma_reset (dma_soft_reset)
  );

endmodule // dgr_global_regs

// [hdl/dgr_pkg.sv]
package dgr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int IDX_W  = 7;

  // offsets are register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SOFT_RESET_CONTROL   = 7'h08;
  localparam logic [IDX_W-1:0] IDX_CONTROLLER_VERSION   = 7'h42;
  localparam logic [IDX_W-1:0] IDX_CHANNEL_TWO_VERSION  = 7'h44;
  localparam logic [IDX_W-1:0] IDX_CHANNEL_ZERO_VERSION = 7'h46;
  localparam logic [IDX_W-1:0] IDX_CHANNEL_ONE_VERSION  = 7'h48;
  localparam logic [IDX_W-1:0] IDX_GRAPHICS_VERSION     = 7'h4a;
  localparam logic [IDX_W-1:0] IDX_DISPLAY_VERSION      = 7'h4c;
  localparam logic [IDX_W-1:0] IDX_CAPABILITY_ZERO_UP   = 7'h4e;
  localparam logic [IDX_W-1:0] IDX_CAPABILITY_ZERO_LOW  = 7'h50;
  localparam logic [IDX_W-1:0] IDX_CAPABILITY_ONE_UP    = 7'h52;

  localparam int SOFT_RESET_TRIGGER_BIT = 0;
  localparam int SOFT_RESET_PULSE_CYCLES = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [REG_W-1:0]  ZERO_REG  = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [11:0] reserved;
    logic        constant_fill_capable;
    logic        transparent_copy_capable;
    logic        overlap_detect_capable;
    logic        directional_copy_capable;
  } dgr_cap0_upper_t;

  typedef struct packed {
    logic [12:0] reserved_hi;
    logic        sub_byte_adjust_capable;
    logic        reserved_mid;
    logic        origin_coord_capable;
  } dgr_cap0_lower_t;

  localparam dgr_cap0_upper_t CAP0_UPPER_VALUE = '{
    reserved                 : 12'h000,
    constant_fill_capable    : 1'b1,
    transparent_copy_capable : 1'b1,
    overlap_detect_capable   : 1'b0,
    directional_copy_capable : 1'b0
  };

  localparam dgr_cap0_lower_t CAP0_LOWER_VALUE = '{
    reserved_hi             : 13'h0000,
    sub_byte_adjust_capable : 1'b0,
    reserved_mid            : 1'b0,
    origin_coord_capable    : 1'b0
  };

  localparam logic [REG_W-1:0] CAP1_UPPER_VALUE = 16'h0000;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [1:0]        resp;
  } dgr_rd_t;

  function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
    return addr[IDX_W+1:2];
  endfunction

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = addr[IDX_W+1:2];
    if (addr[ADDR_W-1:IDX_W+2] != '0) begin
      return 1'b0;
    end
    return (idx == IDX_SOFT_RESET_CONTROL) ||
           (idx >= IDX_CONTROLLER_VERSION && idx <= IDX_CAPABILITY_ONE_UP && !idx[0]);
  endfunction

endpackage

// [hdl/dgr_read_mux.sv]
`timescale 1ns/100ps
module dgr_read_mux #(
  parameter logic [15:0] CONTROLLER_ID = 16'h5a3c, // arbitrary value
  parameter logic [15:0] CHANNEL_ID    = 16'h5a3c  // arbitrary value
) (
  input  wire logic                       clock,     // system clock
  input  wire logic                       sys_rst,   // synchronous reset
  input  wire logic [dgr_pkg::ADDR_W-1:0] rd_addr,   // held read address
  output dgr_pkg::dgr_rd_t                rd_word    // registered data and response
);

  wire logic [dgr_pkg::IDX_W-1:0] idx = dgr_pkg::reg_index(rd_addr);
  wire logic                      hit = dgr_pkg::reg_mapped(rd_addr);
  logic [dgr_pkg::REG_W-1:0]      sel;

  always_comb begin
    case (idx)
      dgr_pkg::IDX_SOFT_RESET_CONTROL:   sel = dgr_pkg::ZERO_REG;
      dgr_pkg::IDX_CONTROLLER_VERSION:   sel = CONTROLLER_ID;
      dgr_pkg::IDX_CHANNEL_TWO_VERSION,
      dgr_pkg::IDX_CHANNEL_ZERO_VERSION,
      dgr_pkg::IDX_CHANNEL_ONE_VERSION,
      dgr_pkg::IDX_GRAPHICS_VERSION,
      dgr_pkg::IDX_DISPLAY_VERSION:      sel = CHANNEL_ID;
      dgr_pkg::IDX_CAPABILITY_ZERO_UP:   sel = dgr_pkg::CAP0_UPPER_VALUE;
      dgr_pkg::IDX_CAPABILITY_ZERO_LOW:  sel = dgr_pkg::CAP0_LOWER_VALUE;
      dgr_pkg::IDX_CAPABILITY_ONE_UP:    sel = dgr_pkg::CAP1_UPPER_VALUE;
      default:                           sel = dgr_pkg::ZERO_REG;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_word <= '0;
    end else begin
      // upper half of the word is always zero; unmapped reads also give zero data
      rd_word.data <= hit ? {16'h0000, sel} : dgr_pkg::ZERO_WORD;
      rd_word.resp <= hit ? dgr_pkg::RESP_OKAY : dgr_pkg::RESP_SLVERR;
    end
  end

endmodule // dgr_read_mux

// [hdl/dgr_soft_reset_gen.sv]
`timescale 1ns/100ps
module dgr_soft_reset_gen #(
  parameter int PULSE_CYCLES = dgr_pkg::SOFT_RESET_PULSE_CYCLES
) (
  input  wire logic clock,       // system clock
  input  wire logic sys_rst,     // synchronous reset
  input  wire logic trigger,     // one-cycle request from a register write
  output logic      dma_reset    // reset to the rest of the controller
);

  localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(PULSE_CYCLES);

  logic [CNT_W-1:0] remaining;

  // the trigger bit itself is never stored, so it clears on its own
  wire logic [CNT_W-1:0] next_remaining = trigger ? LOAD :
                                          (remaining != '0) ? remaining - 1'b1 : remaining;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      remaining <= '0;
      dma_reset <= 1'b0;
    end else begin
      remaining <= next_remaining;
      dma_reset <= (next_remaining != '0);
    end
  end

endmodule // dgr_soft_reset_gen

// [testbench/dgr_global_regs_properties.sv]
`timescale 1ns/100ps
module dgr_global_regs_checker (
  input wire logic        clock,          // system clock
  input wire logic        sys_rst,        // sync reset
  input wire logic [11:0] s_axi_araddr,   // read address
  input wire logic        s_axi_arvalid,  // read addr valid
  input wire logic        s_axi_arready,  // read addr ready
  input wire logic [31:0] s_axi_rdata,    // read data
  input wire logic [1:0]  s_axi_rresp,    // read response
  input wire logic        s_axi_rvalid,   // read valid
  input wire logic        s_axi_rready,   // read ready
  input wire logic [1:0]  s_axi_bresp,    // write response
  input wire logic        s_axi_bvalid,   // write resp valid
  input wire logic        s_axi_bready,   // write resp ready
  input wire logic        s_axi_awready,  // write addr ready
  input wire logic        s_axi_wready,   // write data ready
  input wire logic        dma_soft_reset  // reset pulse
);
  // index of the read in flight, so read data can be tied to its register
  logic [6:0] rd_idx;
  always_ff @(posedge clock) if (s_axi_arvalid && s_axi_arready) rd_idx <= s_axi_araddr[8:2];

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  upper_half_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  trigger_reads_zero_a: assert property (s_axi_rvalid && rd_idx == 7'h08 |-> s_axi_rdata == 32'h0)
    else $error("reset trigger read not zero");
  cap_upper_val_a: assert property (s_axi_rvalid && rd_idx == 7'h4e |-> s_axi_rdata == 32'hc)
    else $error("capability upper value wrong");
  cap_lower_val_a: assert property (s_axi_rvalid && rd_idx == 7'h50 |-> s_axi_rdata == 32'h0)
    else $error("capability lower value wrong");
  slverr_data_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  write_busy_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response dropped early");
  pulse_len_a: assert property ($rose(dma_soft_reset) |-> dma_soft_reset[*4] ##1 !dma_soft_reset)
    else $error("soft reset pulse length wrong");
endmodule // dgr_global_regs_checker

bind dgr_global_regs dgr_global_regs_checker u_dgr_global_regs_checker (.clock, .sys_rst,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_awready, .s_axi_wready,
  .dma_soft_reset);

// [testbench/dgr_global_regs_bench.sv]
`timescale 1ns/100ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module dgr_global_regs_bench;
  localparam logic [15:0] CTRL_ID = 16'h3c5a; // arbitrary value
  localparam logic [15:0] CHAN_ID = 16'h2b7e; // arbitrary value
  logic        clock = 1'b0, sys_rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        dma_soft_reset;
  int          n_errors = 0, samples_checked = 0, hi_cnt;
  logic [11:0] addr_tbl [10] = '{12'h020, 12'h108, 12'h110, 12'h118, 12'h120, 12'h128,
                                 12'h130, 12'h138, 12'h140, 12'h148};
  logic [15:0] exp_tbl [10] = '{16'h0000, CTRL_ID, CHAN_ID, CHAN_ID, CHAN_ID, CHAN_ID,
                                CHAN_ID, 16'h000c, 16'h0000, 16'h0000};
  // only field bits are ever set; reserved bits are written as zero
  logic [15:0] wr_tbl [10] = '{16'h0000, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
                               16'hffff, 16'h000f, 16'h0005, 16'h0000};

  dgr_global_regs #(.CONTROLLER_ID(CTRL_ID), .CHANNEL_ID(CHAN_ID), .SOFT_RESET_CYCLES(4))
  u_dgr_global_regs (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .dma_soft_reset);

  always #20 clock = ~clock;

  task automatic print_verdict;
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic timeout_hit;
    n_errors++;
    $display("[FAIL] bus handshake expected 1 seen 0");
    print_verdict();
  endtask

  // lag holds the ready back so that the answer must stand until it is taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r,
                           input int lag = 0);
    int i;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (i + 1 == lag) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 50) timeout_hit();
  endtask

  task automatic check_read(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er,
                            input int lag = 0);
    int i;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (i + 1 == lag) s_axi_rready <= 1'b1;
    end
    rd_data = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 50) begin
      timeout_hit();
    end else begin
      `CHK("read data", {16'h0000, e}, rd_data)
      `CHK("read response", er, rsp)
    end
  endtask

  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    for (int k = 0; k < 10; k++) check_read(addr_tbl[k], exp_tbl[k], 2'h0);
    // trigger bit kept clear so the reset control write does not fire a pulse
    for (int k = 0; k < 10; k++) begin
      axi_write(addr_tbl[k], {16'h0000, wr_tbl[k]}, rsp);
      `CHK("write response", 2'h0, rsp)
    end
    for (int k = 0; k < 10; k++) check_read(addr_tbl[k], exp_tbl[k], 2'h0);
    check_read(12'h138, 16'h000c, 2'h0, 4);
    axi_write(12'h110, 32'h0000_0000, rsp, 4);
    `CHK("late write response", 2'h0, rsp)
    check_read(12'h110, CHAN_ID, 2'h0);
    axi_write(12'h024, 32'h0000_0000, rsp);
    `CHK("unmapped write response", 2'h2, rsp)
    check_read(12'h024, 16'h0000, 2'h2);
    check_read(12'h10c, 16'h0000, 2'h2);
    `CHK("idle soft reset", 1'b0, dma_soft_reset)
    axi_write(12'h020, 32'h0000_0001, rsp);
    hi_cnt = 0;
    repeat (12) begin
      @(posedge clock);
      if (dma_soft_reset === 1'b1) hi_cnt++;
    end
    `CHK("soft reset pulse cycles", 4, hi_cnt)
    check_read(12'h020, 16'h0000, 2'h0);
    print_verdict();
  end
endmodule // dgr_global_regs_bench
